/* File: drpm_power_mgr.v */
// DDR3 rank power manager and channel pin control
`timescale 1ns/100ps
`default_nettype none
`include "drpm_map.vh"
//
// Operation
// - Outputs to empty or single-sided slots stay tri-stated.
// - Unpopulated rank leaves its chip select and clock enable undriven.
// - After reset all ranks count as populated until software enables tri-state.
// - Independent clock enables drive power-up, self-refresh and both power-downs.
// - Clock enable held low during power-up so DRAM floats data and strobes.
// - Clock enable low during reset until software sets the enable bit.
// - Suspend flushes pending cycles, enters self-refresh, holds clock enable low.
// - Package low-power with no pending requests puts memory in self-refresh.
// - Idle ranks are dynamically powered down by dropping clock enable.
// - Config selects active or precharge power-down; precharge closes pages first.
// - With power-down on, wake all ranks for refresh, sleep them after.
// - Per-slot clock gating; unused channel and empty slot controls disabled.
// - Unused signals get driver off, receiver off and input path gated, except DQ_OE_O and DQS_OE_O, which writes still raise.
// - One differential clock pair per rank, two ranks.
// - One active-low chip select and one clock enable per rank.
// - Commands on row, column, write strobes with 16-bit address, 3-bit bank.
// - 64-bit data, eight masks, eight bidirectional strobe pairs.
// - Mask driven high beside bytes that must not be written.
// - Write strobes change on the same clock edge as data; reads arrive edge-aligned.
// - Termination enable asserted during writes.
module drpm_power_mgr #(
  parameter NR     = `DRPM_RANKS,
  parameter IDLE_W = `DRPM_IDLE_W,
  parameter EXIT_W = `DRPM_EXIT_W
) (
  input  wire                     CLK_I,
  input  wire                     RST_N_I,
  input  wire                     CKE_ENABLE_I,
  input  wire                     TRISTATE_EN_I,
  input  wire [NR-1:0]            RANK_PRESENT_I,
  input  wire                     CHAN_USED_I,
  input  wire                     DYN_PD_EN_I,
  input  wire                     PRECHARGE_PD_I,
  input  wire [IDLE_W-1:0]        IDLE_LIMIT_I,
  input  wire [EXIT_W-1:0]        EXIT_WAIT_I,
  input  wire                     SUSPEND_REQ_I,
  input  wire                     PKG_LOWPWR_I,
  input  wire                     REFRESH_REQ_I,
  input  wire                     REQ_VALID_I,
  input  wire                     REQ_WRITE_I,
  input  wire [0:0]               REQ_RANK_I,
  input  wire [`DRPM_BANK_W-1:0]  REQ_BANK_I,
  input  wire [`DRPM_ADDR_W-1:0]  REQ_ADDR_I,
  input  wire [`DRPM_DQ_W-1:0]    REQ_WDATA_I,
  input  wire [`DRPM_BYTES-1:0]   REQ_BYTE_EN_I,
  input  wire [`DRPM_DQ_W-1:0]    DQ_I,
  input  wire                     MEM_CLK_I,
  output wire                     REQ_READY_O,
  output reg                      RDATA_VALID_O,
  output reg  [`DRPM_DQ_W-1:0]    RDATA_O,
  output reg                      SUSPEND_DONE_O,
  output reg                      REFRESH_DONE_O,
  output reg  [NR-1:0]            RANK_SLEEP_O,
  output reg  [NR-1:0]            CKE_O,
  output wire [NR-1:0]            CKE_OE_O,
  output reg  [NR-1:0]            CS_N_O,
  output wire [NR-1:0]            CS_OE_O,
  output wire [NR-1:0]            CK_P_O,
  output wire [NR-1:0]            CK_N_O,
  output wire [NR-1:0]            CK_OE_O,
  output reg                      RAS_N_O,
  output reg                      CAS_N_O,
  output reg                      WE_N_O,
  output reg  [`DRPM_ADDR_W-1:0]  ADDR_O,
  output reg  [`DRPM_BANK_W-1:0]  BANK_O,
  output wire                     CMD_OE_O,
  output reg  [`DRPM_DQ_W-1:0]    DQ_O,
  output reg                      DQ_OE_O,
  output reg  [`DRPM_BYTES-1:0]   DM_O,
  output reg  [`DRPM_BYTES-1:0]   DQS_P_O,
  output wire [`DRPM_BYTES-1:0]   DQS_N_O,
  output reg                      DQS_OE_O,
  output reg  [NR-1:0]            ODT_O,
  output wire [NR-1:0]            ODT_OE_O,
  output wire                     RX_EN_O
);
  //////////////////////////////////////////////////////////////////////////////
  // Reset release and input synchronisers
  reg        rst_a;
  reg        rst_b;
  wire       rst_n = rst_b;
  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_a <= 1'b0;
      rst_b <= 1'b0;
    end else begin
      rst_a <= 1'b1;
      rst_b <= rst_a;
    end
  end

  reg [2:0]  clk_sync;
  reg [7:0]  ctl_a;
  reg [7:0]  ctl_b;
  wire       cke_en   = ctl_b[0];
  wire       tri_en   = ctl_b[1];
  wire       susp     = ctl_b[2];
  wire       lowpwr   = ctl_b[3];
  wire       dyn_pd   = ctl_b[4];
  wire       pre_pd   = ctl_b[5];
  wire       chan_on  = ctl_b[6];
  always @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      clk_sync <= 3'h0;
      ctl_a    <= 8'h00;
      ctl_b    <= 8'h00;
    end else begin
      clk_sync <= {clk_sync[1:0], MEM_CLK_I};
      ctl_a    <= {1'b0, CHAN_USED_I, PRECHARGE_PD_I, DYN_PD_EN_I,
                   PKG_LOWPWR_I, SUSPEND_REQ_I, TRISTATE_EN_I, CKE_ENABLE_I};
      ctl_b    <= ctl_a;
    end
  end
  wire       ck_level = clk_sync[1];
  wire       ck_rise  = clk_sync[1] & ~clk_sync[2];

  //////////////////////////////////////////////////////////////////////////////
  // Pin enables for populated ranks and used channel
  wire [NR-1:0] rank_on = chan_on ? (tri_en ? RANK_PRESENT_I : {NR{1'b1}})
                                  : {NR{1'b0}};
  assign CKE_OE_O = rank_on;
  assign CS_OE_O  = rank_on;
  assign ODT_OE_O = rank_on;
  assign CK_OE_O  = rank_on;
  assign CMD_OE_O = chan_on;
  assign RX_EN_O  = chan_on;
  assign CK_P_O   = rank_on & {NR{ck_level}};
  assign CK_N_O   = rank_on & {NR{~ck_level}};
  assign DQS_N_O  = ~DQS_P_O & {`DRPM_BYTES{DQS_OE_O}};

  //////////////////////////////////////////////////////////////////////////////
  // Idle detection per rank
  wire [NR-1:0] rank_idle;
  reg  [NR-1:0] rank_busy;
  genvar g;
  generate
    for (g = 0; g < NR; g = g + 1) begin : g_idle
      drpm_rank_idle #(
        .W (IDLE_W)
      ) u_idle (
        .clk_i   (CLK_I),
        .rst_n_i (rst_n),
        .busy_i  (rank_busy[g]),
        .limit_i (IDLE_LIMIT_I),
        .idle_o  (rank_idle[g])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Main sequencer
  localparam S_INIT  = 4'h0;
  localparam S_IDLE  = 4'h1;
  localparam S_WAKE  = 4'h2;
  localparam S_CMD   = 4'h3;
  localparam S_DATA  = 4'h4;
  localparam S_PREA  = 4'h5;
  localparam S_PD    = 4'h6;
  localparam S_REF   = 4'h7;
  localparam S_SRE   = 4'h8;
  localparam S_SR    = 4'h9;
  localparam S_REFW  = 4'hA;

  reg [3:0]        state;
  reg [EXIT_W-1:0] wait_cnt;
  reg [NR-1:0]     pd_target;
  reg [0:0]        cur_rank;
  reg              cur_write;
  reg [`DRPM_DQ_W-1:0] wdata;
  reg [`DRPM_BYTES-1:0] wmask;
  reg [1:0]        beat;

  // Drives one command with chip select on the selected ranks
  task issue;
    input [2:0]      cmd;
    input [NR-1:0]   sel;
    begin
      CS_N_O  <= ~sel;
      RAS_N_O <= cmd[2];
      CAS_N_O <= cmd[1];
      WE_N_O  <= cmd[0];
    end
  endtask

  function [NR-1:0] rank_bit;
    input [0:0] r;
    begin
      rank_bit = {{(NR-1){1'b0}}, 1'b1} << r;
    end
  endfunction

  localparam [31:0]       XPD_ALL = `DRPM_XPD_CYC;
  localparam [EXIT_W-1:0] XPD_MIN = XPD_ALL[EXIT_W-1:0];
  wire [EXIT_W-1:0] xpd = (EXIT_WAIT_I > XPD_MIN) ? EXIT_WAIT_I : XPD_MIN;
  assign REQ_READY_O = (state == S_IDLE) & ~susp & ~REFRESH_REQ_I;

  always @* begin
    rank_busy = {NR{1'b0}};
    if (REQ_VALID_I || state == S_CMD || state == S_DATA)
      rank_busy = rank_bit(REQ_VALID_I ? REQ_RANK_I : cur_rank);
  end

  always @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      state          <= S_INIT;
      wait_cnt       <= {EXIT_W{1'b0}};
      pd_target      <= {NR{1'b0}};
      cur_rank       <= 1'b0;
      cur_write      <= 1'b0;
      wdata          <= {`DRPM_DQ_W{1'b0}};
      wmask          <= {`DRPM_BYTES{1'b0}};
      beat           <= 2'h0;
      CKE_O          <= {NR{1'b0}};
      CS_N_O         <= {NR{1'b1}};
      RAS_N_O        <= 1'b1;
      CAS_N_O        <= 1'b1;
      WE_N_O         <= 1'b1;
      ADDR_O         <= {`DRPM_ADDR_W{1'b0}};
      BANK_O         <= {`DRPM_BANK_W{1'b0}};
      DQ_O           <= {`DRPM_DQ_W{1'b0}};
      DQ_OE_O        <= 1'b0;
      DM_O           <= {`DRPM_BYTES{1'b0}};
      DQS_P_O        <= {`DRPM_BYTES{1'b0}};
      DQS_OE_O       <= 1'b0;
      ODT_O          <= {NR{1'b0}};
      RDATA_VALID_O  <= 1'b0;
      RDATA_O        <= {`DRPM_DQ_W{1'b0}};
      SUSPEND_DONE_O <= 1'b0;
      REFRESH_DONE_O <= 1'b0;
      RANK_SLEEP_O   <= {NR{1'b0}};
    end else begin
      issue(`DRPM_CMD_NOP, {NR{1'b0}});
      RDATA_VALID_O  <= 1'b0;
      REFRESH_DONE_O <= 1'b0;
      if (wait_cnt != {EXIT_W{1'b0}})
        wait_cnt <= wait_cnt - {{(EXIT_W-1){1'b0}}, 1'b1};
      case (state)
        S_INIT: begin
          CKE_O <= {NR{1'b0}};
          if (cke_en) begin
            CKE_O <= {NR{1'b1}};
            state <= S_IDLE;
          end
        end
        S_IDLE: begin
          SUSPEND_DONE_O <= 1'b0;
          if (susp || (lowpwr && !REQ_VALID_I)) begin
            state <= S_PREA;
            pd_target <= {NR{1'b1}};
            issue(`DRPM_CMD_PREA, {NR{1'b1}});
            ADDR_O[`DRPM_A10_BIT] <= 1'b1;
            wait_cnt <= `DRPM_PRE_DEF;
          end else if (REFRESH_REQ_I && !REFRESH_DONE_O) begin
            CKE_O    <= {NR{1'b1}};
            RANK_SLEEP_O <= {NR{1'b0}};
            wait_cnt <= (CKE_O != {NR{1'b1}}) ? xpd
                        : {EXIT_W{1'b0}};
            state    <= S_REF;
          end else if (REQ_VALID_I) begin
            cur_rank  <= REQ_RANK_I;
            cur_write <= REQ_WRITE_I;
            wdata     <= REQ_WDATA_I;
            wmask     <= ~REQ_BYTE_EN_I;
            BANK_O    <= REQ_BANK_I;
            ADDR_O    <= REQ_ADDR_I;
            if (!CKE_O[REQ_RANK_I]) begin
              CKE_O    <= CKE_O | rank_bit(REQ_RANK_I);
              RANK_SLEEP_O <= RANK_SLEEP_O & ~rank_bit(REQ_RANK_I);
              wait_cnt <= xpd;
              state    <= S_WAKE;
            end else begin
              state <= S_CMD;
            end
          end else if (dyn_pd && |(rank_idle & CKE_O & rank_on)) begin
            pd_target <= rank_idle & CKE_O & rank_on;
            if (pre_pd) begin
              issue(`DRPM_CMD_PREA, rank_idle & CKE_O);
              ADDR_O[`DRPM_A10_BIT] <= 1'b1;
              wait_cnt <= `DRPM_PRE_DEF;
            end
            state <= S_PD;
          end
        end
        S_WAKE: if (wait_cnt == {EXIT_W{1'b0}}) state <= S_CMD;
        S_CMD: begin
          issue(cur_write ? `DRPM_CMD_WR : `DRPM_CMD_RD, rank_bit(cur_rank));
          ODT_O <= cur_write ? rank_bit(cur_rank) : {NR{1'b0}};
          beat  <= 2'h0;
          state <= S_DATA;
        end
        S_DATA: begin
          beat <= beat + 2'h1;
          if (cur_write) begin
            DQ_O     <= wdata;
            DQ_OE_O  <= 1'b1;
            DM_O     <= wmask;
            DQS_OE_O <= 1'b1;
            // Strobe toggles each beat on the same clock edge that registers the data
            DQS_P_O  <= {`DRPM_BYTES{beat[0]}};
          end else if (beat == 2'h1) begin
            RDATA_O       <= DQ_I;
            RDATA_VALID_O <= chan_on;
          end
          if (beat == 2'h2) begin
            DQ_OE_O  <= 1'b0;
            DQS_OE_O <= 1'b0;
            DQS_P_O  <= {`DRPM_BYTES{1'b0}};
            DM_O     <= {`DRPM_BYTES{1'b0}};
            ODT_O    <= {NR{1'b0}};
            state    <= S_IDLE;
          end
        end
        S_PD: if (wait_cnt == {EXIT_W{1'b0}}) begin
          CKE_O        <= CKE_O & ~pd_target;
          RANK_SLEEP_O <= RANK_SLEEP_O | pd_target;
          state        <= S_IDLE;
        end
        S_REF: if (wait_cnt == {EXIT_W{1'b0}} && ck_rise) begin
          issue(`DRPM_CMD_REF, {NR{1'b1}});
          wait_cnt <= `DRPM_EXIT_DEF;
          state    <= S_REFW;
        end
        S_REFW: if (wait_cnt == {EXIT_W{1'b0}}) begin
          REFRESH_DONE_O <= 1'b1;
          if (dyn_pd) begin
            CKE_O        <= {NR{1'b0}};
            RANK_SLEEP_O <= {NR{1'b1}};
          end
          state <= S_IDLE;
        end
        S_PREA: if (wait_cnt == {EXIT_W{1'b0}}) begin
          state <= S_SRE;
        end
        S_SRE: begin
          issue(`DRPM_CMD_SRE, {NR{1'b1}});
          CKE_O        <= {NR{1'b0}};
          RANK_SLEEP_O <= {NR{1'b1}};
          state        <= S_SR;
        end
        S_SR: begin
          CKE_O          <= {NR{1'b0}};
          SUSPEND_DONE_O <= susp;
          if (!susp && !(lowpwr && !REQ_VALID_I)) begin
            CKE_O        <= {NR{1'b1}};
            RANK_SLEEP_O <= {NR{1'b0}};
            pd_target    <= {NR{1'b0}};
            wait_cnt     <= `DRPM_EXIT_DEF;
            state        <= S_PD;
          end
        end
        default: state <= S_INIT;
      endcase
    end
  end
endmodule // drpm_power_mgr
`default_nettype wire

/* File: drpm_map.vh */
// Constants for the DDR3 rank power manager
`ifndef DRPM_MAP_VH
`define DRPM_MAP_VH
`define DRPM_RANKS        2
`define DRPM_DQ_W         64
`define DRPM_BYTES        8
`define DRPM_ADDR_W       16
`define DRPM_BANK_W       3
`define DRPM_IDLE_W       16
`define DRPM_IDLE_DEF     16'h0040
`define DRPM_EXIT_W       8
`define DRPM_EXIT_DEF     8'h0A
`define DRPM_PRE_DEF      8'h06
`define DRPM_CLK_NS       10
`define DRPM_XPD_NS       24
// Cycles for power-down exit latency, rounded up
`define DRPM_XPD_CYC      ((`DRPM_XPD_NS + `DRPM_CLK_NS - 1) / `DRPM_CLK_NS)
`define DRPM_CMD_NOP      3'h7
`define DRPM_CMD_REF      3'h1
`define DRPM_CMD_PREA     3'h2
`define DRPM_CMD_SRE      3'h1
`define DRPM_CMD_RD       3'h5
`define DRPM_CMD_WR       3'h4
`define DRPM_CMD_ACT      3'h3
`define DRPM_A10_BIT      10
`endif

/* File: drpm_rank_idle.v */
// Per-rank idle counter that flags a rank idle past its threshold
`timescale 1ns/100ps
`default_nettype none
module drpm_rank_idle #(
  parameter W = 16
) (
  input  wire         clk_i,
  input  wire         rst_n_i,
  input  wire         busy_i,
  input  wire [W-1:0] limit_i,
  output reg          idle_o
);
  reg [W-1:0] count;
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count  <= {W{1'b0}};
      idle_o <= 1'b0;
    end else if (busy_i) begin
      count  <= {W{1'b0}};
      idle_o <= 1'b0;
    end else if (count >= limit_i) begin
      idle_o <= 1'b1;
    end else begin
      count  <= count + {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule // drpm_rank_idle
`default_nettype wire

/* File: drpm_power_mgr_properties.sv */
// Concurrent checks on the rank power manager ports
`timescale 1ns/100ps
`default_nettype none
`include "drpm_map.vh"
module drpm_power_mgr_props #(
  parameter NR = 2
) (
  input wire logic                   CLK_I,
  input wire logic                   RST_N_I,
  input wire logic                   CKE_ENABLE_I,
  input wire logic                   TRISTATE_EN_I,
  input wire logic [NR-1:0]          RANK_PRESENT_I,
  input wire logic                   CHAN_USED_I,
  input wire logic                   DYN_PD_EN_I,
  input wire logic                   REFRESH_REQ_I,
  input wire logic                   REQ_VALID_I,
  input wire logic                   REQ_WRITE_I,
  input wire logic [`DRPM_BYTES-1:0] REQ_BYTE_EN_I,
  input wire logic                   REQ_READY_O,
  input wire logic                   RDATA_VALID_O,
  input wire logic                   SUSPEND_DONE_O,
  input wire logic                   REFRESH_DONE_O,
  input wire logic [NR-1:0]          CKE_O,
  input wire logic [NR-1:0]          CKE_OE_O,
  input wire logic [NR-1:0]          CS_N_O,
  input wire logic [NR-1:0]          CS_OE_O,
  input wire logic [NR-1:0]          CK_OE_O,
  input wire logic                   RAS_N_O,
  input wire logic                   CAS_N_O,
  input wire logic                   WE_N_O,
  input wire logic                   CMD_OE_O,
  input wire logic                   DQ_OE_O,
  input wire logic [`DRPM_BYTES-1:0] DM_O,
  input wire logic [NR-1:0]          ODT_O,
  input wire logic                   RX_EN_O
);
  logic            seen_en;
  wire logic [2:0] cmd = {RAS_N_O, CAS_N_O, WE_N_O};
  wire logic       sel = ~&CS_N_O;
  ////////////////////////////////////////////////////////////////////////////
  // Remembers that software has enabled the clock enables
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) seen_en <= 1'b0;
    else if (CKE_ENABLE_I) seen_en <= 1'b1;
  end
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  property p_mask;
    logic [`DRPM_BYTES-1:0] be;
    first_match((REQ_VALID_I && REQ_READY_O && REQ_WRITE_I,
      be = REQ_BYTE_EN_I) ##[1:20] $rose(DQ_OE_O)) |-> DM_O == ~be;
  endproperty
  ////////////////////////////////////////////////////////////////////////////
  a_cke_held_low: assert property (!seen_en |-> CKE_O == '0 && &CS_N_O)
    else $error("clock enable or select active before enable");
  a_chan_off: assert property ((!CHAN_USED_I)[*3] |->
    !CMD_OE_O && CK_OE_O == '0 && !RX_EN_O && !DQ_OE_O)
    else $error("unused channel still driven");
  a_empty_rank: assert property (TRISTATE_EN_I[*4] |->
    ((CS_OE_O | CKE_OE_O) & ~RANK_PRESENT_I) == '0)
    else $error("empty rank still driven");
  a_all_populated: assert property ((CHAN_USED_I && !TRISTATE_EN_I)[*6] |->
    &CS_OE_O && &CKE_OE_O)
    else $error("rank undriven before tri-state enable");
  a_write_term: assert property (sel && cmd == `DRPM_CMD_WR |->
    (ODT_O & ~CS_N_O) != '0)
    else $error("termination off at write");
  a_mask_bytes: assert property (p_mask)
    else $error("mask not inverse of byte enables");
  a_exit_wait: assert property ($rose(CKE_O[0]) && !REFRESH_REQ_I |->
    (CS_N_O[0])[*3])
    else $error("command too soon after power-down exit");
  a_read_data: assert property (sel && cmd == `DRPM_CMD_RD |->
    ##[1:4] RDATA_VALID_O)
    else $error("read data not returned");
  a_suspend_low: assert property (SUSPEND_DONE_O |->
    CKE_O == '0 && !REQ_READY_O)
    else $error("clock enable high in suspend");
  a_refresh_sleep: assert property (REFRESH_DONE_O && DYN_PD_EN_I |->
    ##[0:3] CKE_O == '0)
    else $error("ranks awake after refresh");
  c_write: cover property (sel && cmd == `DRPM_CMD_WR);
  c_read: cover property (sel && cmd == `DRPM_CMD_RD);
  c_suspend: cover property ($rose(SUSPEND_DONE_O));
  c_refresh: cover property (REFRESH_DONE_O);
endmodule // drpm_power_mgr_props
bind drpm_power_mgr drpm_power_mgr_props #(.NR(NR)) drpm_power_mgr_props_i (
  .CLK_I(CLK_I), .RST_N_I(RST_N_I), .CKE_ENABLE_I(CKE_ENABLE_I),
  .TRISTATE_EN_I(TRISTATE_EN_I), .RANK_PRESENT_I(RANK_PRESENT_I),
  .CHAN_USED_I(CHAN_USED_I), .DYN_PD_EN_I(DYN_PD_EN_I),
  .REFRESH_REQ_I(REFRESH_REQ_I), .REQ_VALID_I(REQ_VALID_I),
  .REQ_WRITE_I(REQ_WRITE_I), .REQ_BYTE_EN_I(REQ_BYTE_EN_I),
  .REQ_READY_O(REQ_READY_O), .RDATA_VALID_O(RDATA_VALID_O),
  .SUSPEND_DONE_O(SUSPEND_DONE_O), .REFRESH_DONE_O(REFRESH_DONE_O),
  .CKE_O(CKE_O), .CKE_OE_O(CKE_OE_O), .CS_N_O(CS_N_O), .CS_OE_O(CS_OE_O),
  .CK_OE_O(CK_OE_O), .RAS_N_O(RAS_N_O), .CAS_N_O(CAS_N_O), .WE_N_O(WE_N_O),
  .CMD_OE_O(CMD_OE_O), .DQ_OE_O(DQ_OE_O), .DM_O(DM_O), .ODT_O(ODT_O),
  .RX_EN_O(RX_EN_O)
);
`default_nettype wire

/* File: drpm_dram_model.sv */
// Behavioural DDR3 device behind the rank power manager
`timescale 1ns/100ps
`default_nettype none
module drpm_dram_model (
  input  wire logic        clk_i,
  input  wire logic [1:0]  cke_i,
  input  wire logic [1:0]  cs_n_i,
  input  wire logic [2:0]  cmd_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [63:0] dq_i,
  input  wire logic        dq_oe_i,
  input  wire logic [7:0]  dm_i,
  output var  logic [63:0] dq_o
);
  logic [63:0] mem [0:15];
  logic [3:0]  wa, ra;
  logic        wp = 1'b0;
  logic [2:0]  rcnt = 3'h0;
  wire logic   sel = |(~cs_n_i & cke_i);
  initial begin
    for (int i = 0; i < 16; i++) mem[i] = 64'h0;
    dq_o = 64'h0;
  end
  // Commands count only on a selected rank with clock enable high
  always @(posedge clk_i) begin
    if (sel && cmd_i == 3'h4) begin
      wa <= addr_i[3:0];
      wp <= 1'b1;
    end
    if (wp && dq_oe_i) begin
      wp <= 1'b0;
      for (int b = 0; b < 8; b++)
        if (!dm_i[b]) mem[wa][8*b +: 8] <= dq_i[8*b +: 8];
    end
    // Read data for five cycles, else a pattern that changes every cycle
    if (sel && cmd_i == 3'h5) begin
      ra <= addr_i[3:0];
      rcnt <= 3'h4;
      dq_o <= mem[addr_i[3:0]];
    end else if (rcnt != 3'h0) begin
      rcnt <= rcnt - 3'h1;
      dq_o <= mem[ra];
    end else dq_o <= ~dq_o;
  end
endmodule // drpm_dram_model
`default_nettype wire

/* File: tb_drpm_power_mgr.sv */
// Testbench for the rank power manager
`timescale 1ns/100ps
`default_nettype none
module tb_drpm_power_mgr;
  logic clk = 0, rst_n = 0, mclk = 0, cke_en = 0, tri_en = 0, used = 1;
  logic dyn = 0, pre = 0, susp = 0, lowp = 0, rfr = 0, v = 0, w = 0;
  logic [0:0] rk = 0;
  logic [1:0] pres = 2'h1;
  logic [15:0] lim = 16'h0008, ad = 16'h0000;
  logic [7:0] xw = 8'h03, ben = 8'hFF;
  logic [63:0] wd = 64'h0, pat = 64'h0123456789ABCDEF;
  logic ready, rvalid, sdone, rdone, ras_n, cas_n, we_n, cmd_oe, dq_oe;
  logic dqs_oe, rx_en;
  logic [1:0] sleep, cke, cke_oe, cs_n, cs_oe, ck_oe, odt, odt_oe;
  logic [1:0] ckp, ckn;
  logic [2:0] bk = 3'h2, bank;
  logic [63:0] rdata, dq_out, dq_in;
  logic [15:0] addr;
  logic [7:0] dm;
  wire logic [3:0] flg = {sdone, rdone, rvalid, ready};
  int failures = 0, n_tests = 0;
  always #5 clk = ~clk;
  initial begin
    #3;
    forever #40 mclk = ~mclk;
  end
  drpm_power_mgr drpm_power_mgr_i (.CLK_I(clk), .RST_N_I(rst_n),
    .CKE_ENABLE_I(cke_en), .TRISTATE_EN_I(tri_en), .RANK_PRESENT_I(pres),
    .CHAN_USED_I(used), .DYN_PD_EN_I(dyn), .PRECHARGE_PD_I(pre),
    .IDLE_LIMIT_I(lim), .EXIT_WAIT_I(xw), .SUSPEND_REQ_I(susp),
    .PKG_LOWPWR_I(lowp), .REFRESH_REQ_I(rfr), .REQ_VALID_I(v),
    .REQ_WRITE_I(w), .REQ_RANK_I(rk), .REQ_BANK_I(bk), .REQ_ADDR_I(ad),
    .REQ_WDATA_I(wd), .REQ_BYTE_EN_I(ben), .DQ_I(dq_in), .MEM_CLK_I(mclk),
    .REQ_READY_O(ready), .RDATA_VALID_O(rvalid), .RDATA_O(rdata),
    .SUSPEND_DONE_O(sdone), .REFRESH_DONE_O(rdone), .RANK_SLEEP_O(sleep),
    .CKE_O(cke), .CKE_OE_O(cke_oe), .CS_N_O(cs_n), .CS_OE_O(cs_oe),
    .CK_P_O(ckp), .CK_N_O(ckn), .CK_OE_O(ck_oe), .RAS_N_O(ras_n),
    .CAS_N_O(cas_n), .WE_N_O(we_n), .ADDR_O(addr), .BANK_O(bank),
    .CMD_OE_O(cmd_oe), .DQ_O(dq_out), .DQ_OE_O(dq_oe), .DM_O(dm),
    .DQS_P_O(), .DQS_N_O(), .DQS_OE_O(dqs_oe), .ODT_O(odt),
    .ODT_OE_O(odt_oe), .RX_EN_O(rx_en));
  drpm_dram_model drpm_dram_model_i (.clk_i(clk), .cke_i(cke),
    .cs_n_i(cs_n), .cmd_i({ras_n, cas_n, we_n}), .addr_i(addr),
    .dq_i(dq_out), .dq_oe_i(dq_oe), .dm_i(dm), .dq_o(dq_in));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [63:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wait_hi(input int b, input int lim_c);
    int k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (flg[b] !== 1'b1 && k < lim_c);
    if (flg[b] !== 1'b1) chk("handshake wait", 1'b1, 1'b0);
    @(posedge clk);
  endtask
  task automatic req(input logic wr, r, input logic [15:0] a,
                     input logic [63:0] d, input logic [7:0] be);
    v <= 1'b1;
    w <= wr;
    rk <= r;
    ad <= a;
    wd <= d;
    ben <= be;
    wait_hi(0, 200);
    v <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic r, input logic [15:0] a, input logic [63:0] e);
    req(1'b0, r, a, 64'h0, 8'hFF);
    wait_hi(1, 40);
    chk("read data", e, rdata);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(20000);
    failures++;
    give_verdict;
  end
  initial begin
    cyc(20);
    rst_n <= 1'b1;
    cyc(8);
    chk("cke at power-up", 2'h0, cke);
    chk("select at power-up", 2'h3, cs_n);
    chk("select drive", 2'h3, cs_oe);
    chk("clock pair", 2'h3, ckp ^ ckn);
    cke_en <= 1'b1;
    cyc(8);
    chk("cke enabled", 2'h3, cke);
    $display("test power-up finished");
    req(1'b1, 1'b0, 16'h0005, pat, 8'h0F);
    req(1'b1, 1'b1, 16'h0006, ~pat, 8'hFF);
    rd(1'b0, 16'h0005, {32'h0, pat[31:0]});
    bk <= 3'h5;
    rd(1'b1, 16'h0006, ~pat);
    chk("bank select", 3'h5, bank);
    $display("test transfers finished");
    dyn <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      pre <= p[0];
      cyc(40);
      chk("ranks asleep", 2'h3, sleep);
      chk("cke asleep", 2'h0, cke);
      rd(1'b1, 16'h0006, ~pat);
    end
    rfr <= 1'b1;
    wait_hi(2, 300);
    rfr <= 1'b0;
    cyc(4);
    chk("cke after refresh", 2'h0, cke);
    $display("test power-down finished");
    dyn <= 1'b0;
    tri_en <= 1'b1;
    cyc(6);
    chk("select drive", 2'h1, cs_oe);
    chk("cke drive", 2'h1, cke_oe);
    chk("term drive", 2'h1, odt_oe);
    susp <= 1'b1;
    wait_hi(3, 200);
    chk("cke suspended", 1'b0, cke[0]);
    chk("ready suspended", 1'b0, ready);
    susp <= 1'b0;
    cyc(20);
    rd(1'b0, 16'h0005, {32'h0, pat[31:0]});
    lowp <= 1'b1;
    cyc(40);
    chk("low-power sleep", 1'b1, sleep[0]);
    chk("low-power cke", 1'b0, cke[0]);
    lowp <= 1'b0;
    cyc(20);
    $display("test sleep states finished");
    used <= 1'b0;
    cyc(6);
    chk("command drive", 1'b0, cmd_oe);
    chk("clock drive", 2'h0, ck_oe);
    chk("clock pair off", 2'h0, ckp | ckn);
    chk("receiver", 1'b0, rx_en);
    $display("test unused channel finished");
    give_verdict;
  end
endmodule // tb_drpm_power_mgr
`default_nettype wire
